// ### verilog/srx_rx_path.sv
// receive coding path: rate-match buffer, decoder, phase-compensation buffer,
// lock and status ports; registers over an AHB-Lite slave
// assumes all inputs synchronous to core_clk; exported clocks are active-edge strobes
`timescale 1ns/100ps
`include "srx_cfg.svh"
module srx_rx_path
	import srx_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [9:0] rx_code,
	input wire logic rx_code_valid,
	input wire logic rx_sync,
	input wire logic local_tick,
	input wire logic tx_tick,
	input wire logic [3:0] slip_in,
	input wire logic force_data_lock,
	input wire logic force_ref_lock,
	input wire logic cdr_auto_ltd,
	input wire logic sig_level,
	input wire logic core_rd,
	output srx_word_t rx_word,
	output logic rx_word_valid,
	output logic rx_clkout,
	output logic tx_clkout,
	output logic rec_clkout,
	output logic pc_fifo_error,
	output logic [3:0] slip_count_out,
	output logic freq_locked,
	output logic sig_detect
);
	// ==========================================
	// register slave
	logic [8:0] ctrl;
	logic wr_pend;
	logic [3:0] wr_addr;
	logic addr_ok;
	logic take;
	logic [31:0] next_hrdata;
	logic [31:0] status_word;
	logic [15:0] ins_cnt;
	logic [15:0] del_cnt;
	logic rm_overflow;

	assign take = hsel && htrans[1] && hready;
	assign addr_ok = haddr[31:4] == 28'h0000000;
	assign next_hrdata = !addr_ok ? 32'h00000000 :
		(haddr[3:0] == `SRX_ADDR_CTRL) ? {23'h000000, ctrl} :
		(haddr[3:0] == `SRX_ADDR_STATUS) ? status_word :
		(haddr[3:0] == `SRX_ADDR_COUNT) ? {del_cnt, ins_cnt} : 32'h00000000;

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend <= 1'b0;
			wr_addr <= 4'h0;
			ctrl <= `SRX_CTRL_RESET;
		end
		else
		begin
			hreadyout <= 1'b1;
			wr_pend <= take && hwrite && addr_ok && hsize == 3'h2;
			wr_addr <= haddr[3:0];
			if (take && !hwrite)
				hrdata <= next_hrdata;
			if (wr_pend && wr_addr == `SRX_ADDR_CTRL)
				ctrl <= hwdata[8:0];
		end
	end

	// ==========================================
	// mode decode
	logic coding;
	logic rm_allowed;
	logic rm_active;
	logic sd_supported;

	assign coding = ctrl[`SRX_C_CODING];
	// receiver-only, coding off or auto sync off forces the rate-match bypass; otherwise either option
	assign rm_allowed = ctrl[`SRX_C_RM_EN] && coding && ctrl[`SRX_C_AUTO_SYNC]
		&& !ctrl[`SRX_C_RX_ONLY];
	assign rm_active = rm_allowed && rx_sync;
	assign sd_supported = (ctrl[`SRX_C_BASIC] && coding) || ctrl[`SRX_C_PIPE];

	// ==========================================
	// rate-match buffer
	// thresholds leave several words of margin both ways; at 600 ppm one
	// skip per few thousand words suffices, far inside the gap between them
	logic [9:0] rm_mem [`SRX_RM_DEPTH];
	logic [4:0] rm_wp;
	logic [4:0] rm_rp;
	logic [4:0] rm_fill;
	logic [9:0] last_out;
	logic in_skip;
	logic last_skip;
	logic rm_del;
	logic rm_push;
	logic rm_ins;
	logic rm_pop;
	logic rm_full;
	logic [9:0] dec_code;
	logic dec_valid;

	assign in_skip = rx_code == `SRX_SKIP_NEG || rx_code == `SRX_SKIP_POS;
	assign last_skip = last_out == `SRX_SKIP_NEG || last_out == `SRX_SKIP_POS;
	assign rm_full = rm_fill == `SRX_RM_LAST + 5'h01;
	assign rm_del = rm_active && rx_code_valid && in_skip && rm_fill >= `SRX_RM_HI;
	assign rm_push = rm_active && rx_code_valid && !rm_del && !rm_full;
	assign rm_ins = rm_active && local_tick && rm_fill <= `SRX_RM_LO && last_skip;
	assign rm_pop = rm_active && local_tick && !rm_ins && rm_fill != 5'h00;
	assign dec_code = rm_ins ? last_out : rm_mem[rm_rp];

	always_ff @(posedge core_clk)
	begin
		if (rm_push)
			rm_mem[rm_wp] <= rx_code;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !rm_active)
		begin
			rm_wp <= 5'h00;
			rm_rp <= 5'h00;
			rm_fill <= 5'h00;
			last_out <= 10'h000;
		end
		else
		begin
			if (rm_push)
				rm_wp <= (rm_wp == `SRX_RM_LAST) ? 5'h00 : rm_wp + 5'h01;
			if (rm_pop)
				rm_rp <= (rm_rp == `SRX_RM_LAST) ? 5'h00 : rm_rp + 5'h01;
			rm_fill <= rm_fill + 5'(rm_push) - 5'(rm_pop);
			if (rm_pop || rm_ins)
				last_out <= dec_code;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ins_cnt <= 16'h0000;
			del_cnt <= 16'h0000;
			rm_overflow <= 1'b0;
		end
		else
		begin
			ins_cnt <= ins_cnt + 16'(rm_ins);
			del_cnt <= del_cnt + 16'(rm_del);
			if (rm_active && rx_code_valid && !rm_del && rm_full)
				rm_overflow <= 1'b1;
		end
	end

	// ==========================================
	// decoder; bypass feeds it straight from the aligner
	srx_sym_t dsym;
	logic dsym_valid;

	srx_decoder srx_decoder_i (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.code(rm_allowed ? dec_code : rx_code),
		.code_valid(rm_allowed ? (rm_pop || rm_ins) : rx_code_valid),
		.sym(dsym),
		.sym_valid(dsym_valid)
	);

	// ==========================================
	// byte deserializer and write-side clocking
	logic wr_phase;
	logic tx_phase;
	logic half;
	srx_sym_t lo_hold;
	logic pc_wr;
	srx_word_t pc_in;

	assign pc_wr = dsym_valid && (!ctrl[`SRX_C_DESER] || half);
	assign pc_in = ctrl[`SRX_C_DESER] ? {dsym, lo_hold} : {11'h000, dsym};

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			half <= 1'b0;
			lo_hold <= '0;
			wr_phase <= 1'b0;
			tx_phase <= 1'b0;
		end
		else
		begin
			if (dsym_valid)
			begin
				half <= ctrl[`SRX_C_DESER] && !half;
				lo_hold <= dsym;
			end
			if (dsym_valid)
				wr_phase <= !wr_phase;
			if (tx_tick)
				tx_phase <= !tx_phase;
		end
	end

	// ==========================================
	// phase-compensation buffer
	srx_word_t pc_mem [`SRX_PC_DEPTH];
	logic [`SRX_PC_AW-1:0] pc_wp;
	logic [`SRX_PC_AW-1:0] pc_rp;
	logic [2:0] pc_fill;
	logic pc_push;
	logic pc_pull;

	assign pc_push = pc_wr && pc_fill != `SRX_PC_DEPTH;
	assign pc_pull = core_rd && pc_fill != 3'h0;

	always_ff @(posedge core_clk)
	begin
		if (pc_push)
			pc_mem[pc_wp] <= pc_in;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pc_wp <= '0;
			pc_rp <= '0;
			pc_fill <= 3'h0;
			rx_word <= '0;
			rx_word_valid <= 1'b0;
		end
		else
		begin
			if (pc_push)
				pc_wp <= pc_wp + 2'h1;
			if (pc_pull)
				pc_rp <= pc_rp + 2'h1;
			pc_fill <= pc_fill + 3'(pc_push) - 3'(pc_pull);
			rx_word_valid <= pc_pull;
			if (pc_pull)
				rx_word <= pc_mem[pc_rp];
		end
	end

	// ==========================================
	// status outputs
	srx_lock_mode_t lock_mode;
	logic next_locked;

	assign lock_mode = force_data_lock ? SRX_LOCK_DATA :
		force_ref_lock ? SRX_LOCK_REF : SRX_LOCK_AUTO;

	always_comb
	begin
		case (lock_mode)
			SRX_LOCK_DATA: next_locked = 1'b1;
			SRX_LOCK_REF: next_locked = 1'b0;
			SRX_LOCK_AUTO: next_locked = cdr_auto_ltd;
			default: next_locked = 1'b0;
		endcase
	end

	assign status_word = {21'h000000, rm_overflow, pc_fifo_error, rm_fill,
		freq_locked, rm_active, sig_detect, rx_sync};

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			freq_locked <= 1'b0;
			pc_fifo_error <= 1'b1;
			slip_count_out <= 4'h0;
			sig_detect <= 1'b1;
			rx_clkout <= 1'b0;
			tx_clkout <= 1'b0;
			rec_clkout <= 1'b0;
		end
		else
		begin
			freq_locked <= next_locked;
			// reflects the fill after this cycle's push and pull
			pc_fifo_error <= (pc_fill + 3'(pc_push) - 3'(pc_pull) == `SRX_PC_DEPTH)
				|| (pc_fill + 3'(pc_push) - 3'(pc_pull) == 3'h0);
			if (!ctrl[`SRX_C_AUTO_SYNC])
				slip_count_out <= (slip_in > `SRX_SLIP_MAX) ? `SRX_SLIP_MAX : slip_in;
			else
				slip_count_out <= 4'h0;
			sig_detect <= sd_supported ? sig_level : 1'b1;
			rx_clkout <= pc_wr;
			tx_clkout <= tx_tick && (!ctrl[`SRX_C_SER] || tx_phase);
			rec_clkout <= ctrl[`SRX_C_GIGE] && dsym_valid;
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_rm_sync_gate: assert property (!rx_sync |-> !rm_push && !rm_pop)
		else $error("rate match ran without sync");
	chk_rm_mode_gate: assert property (rm_active |-> coding && !ctrl[`SRX_C_RX_ONLY])
		else $error("rate match active in illegal mode");
	chk_rm_depth: assert property (rm_fill <= `SRX_RM_LAST + 5'h01)
		else $error("rate-match fill above depth");
	chk_ins_skip: assert property (rm_ins |-> last_skip && rm_fill <= `SRX_RM_LO)
		else $error("insert of non-skip or above low mark");
	chk_del_skip: assert property (rm_del |-> in_skip ##1 del_cnt == $past(del_cnt) + 16'h0001)
		else $error("delete not counted or not a skip");
	chk_lock_data: assert property (force_data_lock |=> freq_locked)
		else $error("forced data lock not reported");
	chk_lock_ref: assert property (!force_data_lock && force_ref_lock |=> !freq_locked)
		else $error("forced reference lock not reported");
	chk_pc_error: assert property (pc_fill == 3'h0 && !$past(pc_push) |-> pc_fifo_error)
		else $error("empty buffer without error flag");
	chk_slip_range: assert property (slip_count_out <= `SRX_SLIP_MAX)
		else $error("slip count above nine");
	chk_sd_forced: assert property (!sd_supported |=> sig_detect)
		else $error("signal detect not forced high");
	chk_deser_pair: assert property (ctrl[`SRX_C_DESER] && pc_wr |-> !$past(pc_wr))
		else $error("deserialized writes back to back");
	chk_rec_gige: assert property (!ctrl[`SRX_C_GIGE] |=> !rec_clkout)
		else $error("recovered clock outside gigabit mode");
endmodule // srx_rx_path

// ### pkg/srx_cfg.svh
// constants of the receive rate-match and decode path
// assumes inclusion by the bench and by each design file that needs them
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH

// ==========================================
// register map, byte addresses
`define SRX_ADDR_CTRL 4'h0
`define SRX_ADDR_STATUS 4'h4
`define SRX_ADDR_COUNT 4'h8
`define SRX_CTRL_RESET 9'h030

// ==========================================
// control fields
`define SRX_C_RM_EN 0
`define SRX_C_DESER 1
`define SRX_C_SER 2
`define SRX_C_RX_ONLY 3
`define SRX_C_CODING 4
`define SRX_C_AUTO_SYNC 5
`define SRX_C_GIGE 6
`define SRX_C_BASIC 7
`define SRX_C_PIPE 8

// ==========================================
// rate-match buffer
`define SRX_RM_DEPTH 20
`define SRX_RM_LAST 5'h13
`define SRX_RM_HI 5'h0f
`define SRX_RM_LO 5'h05
`define SRX_SKIP_NEG 10'h0bc
`define SRX_SKIP_POS 10'h343
`define SRX_SLIP_MAX 4'h9

// ==========================================
// phase-compensation buffer
`define SRX_PC_DEPTH 3'h4
`define SRX_PC_AW 2
`endif

// ### pkg/srx_pkg.sv
// types shared by the receive rate-match and decode path
// assumes srx_cfg.svh beside it
package srx_pkg;
	typedef enum logic [1:0] {
		SRX_LOCK_AUTO = 2'h0,
		SRX_LOCK_REF = 2'h1,
		SRX_LOCK_DATA = 2'h2
	} srx_lock_mode_t;

	typedef struct packed {
		logic disp_err;
		logic code_err;
		logic k;
		logic [7:0] data;
	} srx_sym_t;

	typedef struct packed {
		srx_sym_t hi;
		srx_sym_t lo;
	} srx_word_t;
endpackage

// ### verilog/srx_decoder.sv
// 10-bit to 8-bit line decoder with control flag and running disparity check
// assumes code bit 0 is the first bit on the line (a), bit 9 the last (j)
`timescale 1ns/100ps
`include "srx_cfg.svh"
module srx_decoder
	import srx_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [9:0] code,
	input wire logic code_valid,
	output srx_sym_t sym,
	output logic sym_valid
);
	logic [5:0] six;
	logic [3:0] four;
	logic [3:0] four_eff;
	logic [5:0] dec5;
	logic [3:0] dec3;
	logic k28;
	logic alt7;
	logic k_alt;
	logic [3:0] ones;
	logic rd_pos;
	logic bad_disp;

	assign six = {code[0], code[1], code[2], code[3], code[4], code[5]};
	assign four = {code[6], code[7], code[8], code[9]};
	assign k28 = (six == 6'h0f) || (six == 6'h30);
	// high-disparity control groups carry an inverted 4-bit part
	assign four_eff = (six == 6'h30) ? ~four : four;
	assign alt7 = (four == 4'h7) || (four == 4'h8);
	assign ones = 4'(code[0] + code[1] + code[2] + code[3] + code[4] + code[5] + code[6]
		+ code[7] + code[8] + code[9]);
	assign bad_disp = (rd_pos && ones > 4'h5) || (!rd_pos && ones < 4'h5);
	assign k_alt = alt7 && (dec5 == 6'h17 || dec5 == 6'h1b || dec5 == 6'h1d || dec5 == 6'h1e);

	// dec5[5] marks an illegal group
	always_comb
	begin
		case (six)
			6'h27, 6'h18: dec5 = 6'h00; 6'h1d, 6'h22: dec5 = 6'h01;
			6'h2d, 6'h12: dec5 = 6'h02; 6'h31: dec5 = 6'h03;
			6'h35, 6'h0a: dec5 = 6'h04; 6'h29: dec5 = 6'h05;
			6'h19: dec5 = 6'h06; 6'h38, 6'h07: dec5 = 6'h07;
			6'h39, 6'h06: dec5 = 6'h08; 6'h25: dec5 = 6'h09;
			6'h15: dec5 = 6'h0a; 6'h34: dec5 = 6'h0b;
			6'h0d: dec5 = 6'h0c; 6'h2c: dec5 = 6'h0d;
			6'h1c: dec5 = 6'h0e; 6'h17, 6'h28: dec5 = 6'h0f;
			6'h1b, 6'h24: dec5 = 6'h10; 6'h23: dec5 = 6'h11;
			6'h13: dec5 = 6'h12; 6'h32: dec5 = 6'h13;
			6'h0b: dec5 = 6'h14; 6'h2a: dec5 = 6'h15;
			6'h1a: dec5 = 6'h16; 6'h3a, 6'h05: dec5 = 6'h17;
			6'h33, 6'h0c: dec5 = 6'h18; 6'h26: dec5 = 6'h19;
			6'h16: dec5 = 6'h1a; 6'h36, 6'h09: dec5 = 6'h1b;
			6'h0e: dec5 = 6'h1c; 6'h2e, 6'h11: dec5 = 6'h1d;
			6'h1e, 6'h21: dec5 = 6'h1e; 6'h2b, 6'h14: dec5 = 6'h1f;
			6'h0f, 6'h30: dec5 = 6'h1c;
			default: dec5 = 6'h20;
		endcase
	end

	// dec3[3] marks an illegal group
	always_comb
	begin
		case (four_eff)
			4'hb, 4'h4: dec3 = 4'h0; 4'h9: dec3 = 4'h1;
			4'h5: dec3 = 4'h2; 4'hc, 4'h3: dec3 = 4'h3;
			4'hd, 4'h2: dec3 = 4'h4; 4'ha: dec3 = 4'h5;
			4'h6: dec3 = 4'h6; 4'he, 4'h1, 4'h7, 4'h8: dec3 = 4'h7;
			default: dec3 = 4'h8;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sym <= '0;
			sym_valid <= 1'b0;
			rd_pos <= 1'b0;
		end
		else
		begin
			sym_valid <= code_valid;
			if (code_valid)
			begin
				sym.data <= {dec3[2:0], dec5[4:0]};
				sym.k <= k28 || k_alt;
				sym.code_err <= dec5[5] || dec3[3];
				sym.disp_err <= bad_disp;
				if (ones != 4'h5)
					rd_pos <= (ones > 4'h5);
			end
		end
	end
endmodule // srx_decoder

// ### tb/srx_far_model.sv
// far-side model: upstream transmitter handing over one code group per request
// assumes the receive path shares core_clk; slow adds a few idle cycles first
`timescale 1ns/100ps
module srx_far_model
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic slow,
	input wire logic [9:0] code_in,
	output logic [9:0] rx_code,
	output logic rx_code_valid,
	output logic done
);
	logic busy;
	logic [1:0] wait_n;

	// ==========================================
	// send one 8b10b code group per request
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rx_code <= 10'h000;
			rx_code_valid <= 1'b0;
			done <= 1'b0;
			busy <= 1'b0;
			wait_n <= 2'h0;
		end
		else
		begin
			rx_code_valid <= 1'b0;
			done <= 1'b0;
			// stale code must not look valid between groups
			if (rx_code_valid)
				rx_code <= ~rx_code;
			if (go && !busy)
			begin
				busy <= 1'b1;
				wait_n <= slow ? 2'h3 : 2'h0;
			end
			else if (busy && wait_n != 2'h0)
				wait_n <= wait_n - 2'h1;
			else if (busy)
			begin
				rx_code <= code_in;
				rx_code_valid <= 1'b1;
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule // srx_far_model

// ### tb/test_serial_rx_rate_match_decode.sv
// self-checking bench of the receive rate-match and decode path
// assumes srx_pkg compiled first and srx_cfg.svh on the include path
`timescale 1ns/100ps
`include "srx_cfg.svh"
module test_serial_rx_rate_match_decode;
	import srx_pkg::*;
	logic core_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rx_sync = 0, local_tick = 0;
	logic tx_tick = 0, force_data_lock = 0, force_ref_lock = 0, cdr_auto_ltd = 0;
	logic sig_level = 0, core_rd = 0, go = 0, slow = 0, done, hready, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, s;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [3:0] slip_in = 0, slip_count_out;
	logic [9:0] rx_code, code_in = 0;
	logic rx_code_valid, rx_word_valid, rx_clkout, tx_clkout, rec_clkout;
	logic pc_fifo_error, freq_locked, sig_detect;
	srx_word_t rx_word;
	int error_cnt = 0, n_compared = 0, n_rx = 0, n_tx = 0, n_rec = 0;

	assign hready = hreadyout;
	always #25 core_clk = ~core_clk;
	// strobes counted on the far edge, clear of the drivers
	always @(negedge core_clk)
	begin
		n_rx += rx_clkout;
		n_tx += tx_clkout;
		n_rec += rec_clkout;
	end

	srx_rx_path srx_rx_path_i (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_code, .rx_code_valid, .rx_sync,
		.local_tick, .tx_tick, .slip_in, .force_data_lock, .force_ref_lock, .cdr_auto_ltd,
		.sig_level, .core_rd, .rx_word, .rx_word_valid, .rx_clkout, .tx_clkout, .rec_clkout,
		.pc_fifo_error, .slip_count_out, .freq_locked, .sig_detect);
	srx_far_model srx_far_model_i (.core_clk, .rst_n, .go, .slow, .code_in, .rx_code,
		.rx_code_valid, .done);

	// ==========================================
	// helpers
	task final_report;
		$display("compared=%0d mismatches=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [35:0] g, input logic [35:0] e);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// bounded wait for a sampled-high flag; a timeout ends the run
	task wait_hi(input int which);
		int n;
		n = 0;
		@(posedge core_clk);
		while ((which == 0 ? hreadyout : which == 1 ? done : rx_word_valid) !== 1'b1)
		begin
			n++;
			if (n > 50)
			begin
				chk(36'h0, 36'h1);
				final_report;
			end
			@(posedge core_clk);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {28'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_hi(0);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_hi(0);
		rd = hrdata;
	endtask
	task wr(input logic [31:0] d);
		bus(1'b1, `SRX_ADDR_CTRL, d, s);
	endtask
	task send(input logic [9:0] c, input logic sl);
		@(posedge core_clk);
		go <= 1'b1;
		code_in <= c;
		slow <= sl;
		@(posedge core_clk);
		go <= 1'b0;
		wait_hi(1);
	endtask
	task pop(input srx_word_t e);
		@(posedge core_clk);
		core_rd <= 1'b1;
		@(posedge core_clk);
		core_rd <= 1'b0;
		wait_hi(2);
		chk(rx_word, e);
	endtask
	function srx_word_t sw(input logic k1, input logic [7:0] d1, input logic k0,
		input logic [7:0] d0);
		return {2'h0, k1, d1, 2'h0, k0, d0};
	endfunction

	// ==========================================
	// scenarios
	task t_reset;
		bus(1'b0, `SRX_ADDR_CTRL, 32'h0, s);
		chk(36'(s), 36'h030);
		bus(1'b0, 4'hc, 32'h0, s);
		chk(36'(s), 36'h0);
		chk(36'(pc_fifo_error), 36'h1);
		chk(36'(sig_detect), 36'h1);
		chk(36'(hresp), 36'h0);
		$display("test reset done");
	endtask
	task t_decode;
		wr(32'h050);
		n_rx = 0;
		n_rec = 0;
		send(10'h17c, 1'b0);
		send(10'h155, 1'b1);
		send(10'h283, 1'b0);
		send(10'h155, 1'b0);
		clk(3);
		chk(36'(pc_fifo_error), 36'h1);
		chk(36'(n_rx), 36'h4);
		chk(36'(n_rec), 36'h4);
		pop(sw(1'b0, 8'h00, 1'b1, 8'hbc));
		clk(1);
		chk(36'(pc_fifo_error), 36'h0);
		pop(sw(1'b0, 8'h00, 1'b0, 8'hb5));
		pop(sw(1'b0, 8'h00, 1'b1, 8'hbc));
		pop(sw(1'b0, 8'h00, 1'b0, 8'hb5));
		clk(2);
		chk(36'(pc_fifo_error), 36'h1);
		$display("test decode done");
	endtask
	task t_deser;
		wr(32'h012);
		n_rx = 0;
		n_rec = 0;
		send(10'h17c, 1'b1);
		send(10'h155, 1'b0);
		clk(3);
		chk(36'(n_rx), 36'h1);
		chk(36'(n_rec), 36'h0);
		pop(sw(1'b0, 8'hb5, 1'b1, 8'hbc));
		$display("test deser done");
	endtask
	task t_rate;
		wr(32'h031);
		send(`SRX_SKIP_POS, 1'b0);
		bus(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
		chk(36'(s[8:2]), 36'h0);
		rx_sync <= 1'b1;
		repeat (17) send(`SRX_SKIP_POS, 1'b0);
		bus(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
		chk(36'(s[8:4]), 36'hf);
		chk(36'(s[2]), 36'h1);
		bus(1'b0, `SRX_ADDR_COUNT, 32'h0, s);
		chk(36'(s[31:16]), 36'h2);
		repeat (30)
		begin
			@(posedge core_clk);
			local_tick <= 1'b1;
			@(posedge core_clk);
			local_tick <= 1'b0;
		end
		bus(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
		chk(36'(s[8:4]), 36'h5);
		bus(1'b0, `SRX_ADDR_COUNT, 32'h0, s);
		chk(36'(s[15:0] != 16'h0), 36'h1);
		wr(32'h039);
		clk(2);
		bus(1'b0, `SRX_ADDR_STATUS, 32'h0, s);
		chk(36'(s[2]), 36'h0);
		$display("test rate match done");
	endtask
	task t_lock;
		for (int i = 0; i < 8; i++)
		begin
			force_data_lock <= i[2];
			force_ref_lock <= i[1];
			cdr_auto_ltd <= i[0];
			clk(3);
			chk(36'(freq_locked), i[2] ? 36'h1 : i[1] ? 36'h0 : 36'(i[0]));
		end
		$display("test lock done");
	endtask
	task t_slip;
		wr(32'h010);
		slip_in <= 4'hc;
		clk(3);
		chk(36'(slip_count_out), 36'h9);
		slip_in <= 4'h7;
		clk(3);
		chk(36'(slip_count_out), 36'h7);
		wr(32'h030);
		clk(3);
		chk(36'(slip_count_out), 36'h0);
		$display("test slip done");
	endtask
	task t_sig;
		logic [9:0] tbl [5] = '{10'h010, 10'h120, 10'h121, 10'h200, 10'h201};
		for (int i = 0; i < 5; i++)
		begin
			wr({23'h0, tbl[i][9:1]});
			sig_level <= tbl[i][0];
			clk(3);
			chk(36'(sig_detect), i == 0 ? 36'h1 : 36'(tbl[i][0]));
		end
		$display("test signal detect done");
	endtask
	task t_tx;
		for (int m = 0; m < 2; m++)
		begin
			wr(m == 1 ? 32'h004 : 32'h000);
			n_tx = 0;
			repeat (4)
			begin
				@(posedge core_clk);
				tx_tick <= 1'b1;
				@(posedge core_clk);
				tx_tick <= 1'b0;
			end
			clk(3);
			chk(36'(n_tx), m == 1 ? 36'h2 : 36'h4);
		end
		$display("test transmit clock done");
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_decode;
		t_deser;
		t_rate;
		t_lock;
		t_slip;
		t_sig;
		t_tx;
		final_report;
	end
endmodule // test_serial_rx_rate_match_decode
